// ==== hdl/sc_params.svh ====
// constants for the slip compensation and stall prevention core
// assumes a 125 MHz clock and 16-bit settings in documented units
`ifndef SC_PARAMS_SVH
`define SC_PARAMS_SVH
// timing
`define SC_CLK_NS       8
`define SC_TICK_NS      10000
`define SC_TICK_CYC     (`SC_TICK_NS / `SC_CLK_NS)
`define SC_MS_NS        1000000
`define SC_MS_TICKS     (`SC_MS_NS / `SC_TICK_NS)
`define SC_OL_HOLD_MS   100
`define SC_OL_UNIT_MS   100
// apb word indices and control bits
`define SC_W_CTRL       4'h0
`define SC_W_LAST       4'h7
`define SC_W_STAT       4'h8
`define SC_RATE_BIT     16
`define SC_CLR_BIT      17
// field indices in the setting store
`define SC_I_SLIP       4'h2
`define SC_I_TC         4'h3
`define SC_I_CP         4'h4
`define SC_I_BASE       4'h5
`define SC_I_LVL        4'h6
`define SC_I_FAC        4'h7
`define SC_I_LV2        4'h8
`define SC_I_F2         4'h9
`define SC_I_A0         4'ha
`define SC_I_A10        4'hb
`define SC_I_RED        4'hc
`define SC_I_OPS        4'hd
`define SC_I_DLY        4'he
`define SC_I_VRED       4'hf
// codes, ranges and defaults
`define SC_NONE         16'hffff
`define SC_PCT100       16'h03e8
`define SC_SLIP_MAX     16'h1388
`define SC_TC_MAX       16'h03e8
`define SC_FRQ_MAX      16'h9c40
`define SC_LVL_MAX      16'h04b0
`define SC_FAC_MAX      16'h05dc
`define SC_OPS_MAX      16'h001f
`define SC_OPS_A        16'h0064
`define SC_OPS_B        16'h0065
`define SC_DLY_MAX      16'h00fa
`define SC_D_TC         16'h0032
`define SC_D_FRQ        16'h1388
`define SC_D_LVL        16'h044c
`define SC_D_A10        16'h04b0
`define SC_D_VRED       16'h0001
`define SC_LVL_MAX_ALT  16'h05dc
`define SC_D_LVL_ALT    16'h04b0
`define SC_FAST_LVL     16'h0708
`define SC_SLIP_DIV     48'h0000_0098_9680
`endif

// ==== hdl/sc_pkg.sv ====
// types for the slip compensation and stall prevention core
// assumes nothing beyond the parameter header
package sc_pkg;
  // overload flag sequencer
  typedef enum logic [1:0] {
    SC_FLAG_IDLE,
    SC_FLAG_WAIT,
    SC_FLAG_ON
  } sc_flag_state_type;
endpackage

// ==== hdl/sc_slip_stall.sv ====
// slip compensation, stall prevention and overload flag with apb regs
// assumes current, frequency, phase and analog inputs are on clk_i;
// the second function select pin is asynchronous
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "sc_params.svh"
module sc_slip_stall
  import sc_pkg::*;
#(
  parameter logic [15:0] LVL_MAX_ALT = `SC_LVL_MAX_ALT,
  parameter logic [15:0] LVL_DEF_ALT = `SC_D_LVL_ALT,
  parameter logic [15:0] FAST_LVL    = `SC_FAST_LVL
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [15:0] out_current_i,
  input  wire logic [15:0] out_freq_i,
  input  wire logic [11:0] analog_level_i,
  input  wire logic        accel_i,
  input  wire logic        decel_i,
  input  wire logic        second_function_select_i,
  output logic      [15:0] slip_comp_freq_o,
  output logic             stall_hold_accel_o,
  output logic             stall_decel_o,
  output logic             stall_hold_decel_o,
  output logic             voltage_reduce_o,
  output logic             output_shutoff_o,
  output logic             overload_stall_flag_o
);

  logic [15:0] prm_reg [2:15]; // setting store
  logic [15:0] ugrs_reg;       // user group read selection
  logic        rate_reg;       // multiple rating selection
  logic [31:0] rdata_reg;      // read data, caught in setup
  logic [31:0] rd_word;        // read mux
  logic [3:0]  widx;           // word index
  logic        unmapped;       // no register here
  logic        locked;         // setting write refused
  logic        wr_en;          // mapped write access, locked or not
  logic        clr;            // full setting clear
  logic [15:0] slip;           // settings by name
  logic [15:0] tcon;
  logic [15:0] cpsel;
  logic [15:0] fbase;
  logic [15:0] lvl1;
  logic [15:0] fac;
  logic [15:0] lvl2;
  logic [15:0] frq2;
  logic [15:0] ana0;
  logic [15:0] ana10;
  logic [15:0] fred;
  logic [15:0] opsel;
  logic [15:0] dly;
  logic [15:0] vred;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // power-on or cleared value of each setting
  function automatic logic [15:0] sc_def(input logic [3:0] i,
                                         input logic       alt);
    case (i)
      `SC_I_SLIP, `SC_I_CP, `SC_I_FAC: sc_def = `SC_NONE;
      `SC_I_TC:                        sc_def = `SC_D_TC;
      `SC_I_BASE, `SC_I_RED:           sc_def = `SC_D_FRQ;
      `SC_I_LVL, `SC_I_LV2, `SC_I_A0:
        sc_def = alt ? LVL_DEF_ALT : `SC_D_LVL;
      `SC_I_A10: sc_def = alt ? LVL_DEF_ALT : `SC_D_A10;
      `SC_I_VRED: sc_def = `SC_D_VRED;
      default:   sc_def = 16'h0000;
    endcase
  endfunction

  // accepted range of each setting; others keep the old value
  function automatic logic sc_ok(input logic [3:0]  i,
                                 input logic [15:0] v,
                                 input logic        alt);
    logic [15:0] lm;
    lm = alt ? LVL_MAX_ALT : `SC_LVL_MAX;
    case (i)
      `SC_I_SLIP: sc_ok = v <= `SC_SLIP_MAX || v == `SC_NONE;
      `SC_I_TC:   sc_ok = v != 16'h0000 && v <= `SC_TC_MAX;
      `SC_I_CP:   sc_ok = v == 16'h0000 || v == `SC_NONE;
      `SC_I_LVL:  sc_ok = v <= lm || v == `SC_NONE;
      `SC_I_FAC:  sc_ok = v <= `SC_FAC_MAX || v == `SC_NONE;
      `SC_I_F2:   sc_ok = v <= `SC_FRQ_MAX || v == `SC_NONE;
      `SC_I_LV2, `SC_I_A0, `SC_I_A10: sc_ok = v <= lm;
      `SC_I_OPS:  sc_ok = v <= `SC_OPS_MAX || v == `SC_OPS_A ||
                          v == `SC_OPS_B;
      `SC_I_DLY:  sc_ok = v <= `SC_DLY_MAX || v == `SC_NONE;
      `SC_I_VRED: sc_ok = v <= `SC_D_VRED;
      default:    sc_ok = v <= `SC_FRQ_MAX;
    endcase
  endfunction

  // operation select bit: 0 fast limit, 1 accel, 2 constant,
  // 3 decel, 4 output stops while flagged; 100/101 fold to 0/1
  function automatic logic sc_op_off(input logic [15:0] s,
                                     input int          b);
    logic [4:0] m;
    m = (s >= `SC_OPS_A) ? 5'(s - `SC_OPS_A) : s[4:0];
    sc_op_off = m[b];
  endfunction

  assign slip  = prm_reg[`SC_I_SLIP];
  assign tcon  = prm_reg[`SC_I_TC];
  assign cpsel = prm_reg[`SC_I_CP];
  assign fbase = prm_reg[`SC_I_BASE];
  assign lvl1  = prm_reg[`SC_I_LVL];
  assign fac   = prm_reg[`SC_I_FAC];
  assign lvl2  = prm_reg[`SC_I_LV2];
  assign frq2  = prm_reg[`SC_I_F2];
  assign ana0  = prm_reg[`SC_I_A0];
  assign ana10 = prm_reg[`SC_I_A10];
  assign fred  = prm_reg[`SC_I_RED];
  assign opsel = prm_reg[`SC_I_OPS];
  assign dly   = prm_reg[`SC_I_DLY];
  assign vred  = prm_reg[`SC_I_VRED];

  // apb decode; zero wait states, read data caught in setup
  assign widx     = paddr_i[5:2];
  assign unmapped = paddr_i[7:6] != 2'b00 || paddr_i[1:0] != 2'b00 ||
                    widx > `SC_W_STAT;
  assign locked   = ugrs_reg != 16'h0000 && widx != `SC_W_CTRL &&
                    widx != `SC_W_STAT;
  assign wr_en    = psel_i && penable_i && pwrite_i && !unmapped;
  assign clr      = wr_en && widx == `SC_W_CTRL &&
                    pwdata_i[`SC_CLR_BIT];
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i &&
                     (unmapped || (pwrite_i && locked));
  assign prdata_o  = rdata_reg;

  // control word: group selection and rating, always writable
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ugrs_reg <= 16'h0000;
      rate_reg <= 1'b0;
    end else if (wr_en && widx == `SC_W_CTRL) begin
      ugrs_reg <= pwdata_i[15:0];
      rate_reg <= pwdata_i[`SC_RATE_BIT];
    end
  end

  // setting store; a clear takes the rating written with it
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      for (int k = 2; k < 16; k++) begin
        prm_reg[k] <= sc_def(4'(k), 1'b0);
      end
    end else if (clr) begin
      for (int k = 2; k < 16; k++) begin
        prm_reg[k] <= sc_def(4'(k), pwdata_i[`SC_RATE_BIT]);
      end
    end else if (wr_en && !locked && widx <= `SC_W_LAST &&
                 widx != `SC_W_CTRL) begin
      for (int h = 0; h < 2; h++) begin
        if (sc_ok({widx[2:0], h[0]}, pwdata_i[16*h +: 16], rate_reg))
        begin
          prm_reg[{widx[2:0], h[0]}] <= pwdata_i[16*h +: 16];
        end
      end
    end
  end

  a_wr_lock: assert property (
    psel_i && penable_i && pwrite_i && locked && widx == 4'h3
    |=> $stable(lvl1) && $stable(fac))
    else $error("locked write changed a setting");

  // 10 us and 1 ms enables from one prescaler chain
  logic [10:0] pre_reg;
  logic [6:0]  ms_reg;
  logic        tick_10us;
  logic        tick_ms;
  assign tick_10us = pre_reg == 11'(`SC_TICK_CYC - 1);
  assign tick_ms   = tick_10us && ms_reg == 7'(`SC_MS_TICKS - 1);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pre_reg <= 11'h000;
    end else begin
      pre_reg <= tick_10us ? 11'h000 : pre_reg + 11'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ms_reg <= 7'h00;
    end else if (tick_10us) begin
      ms_reg <= tick_ms ? 7'h00 : ms_reg + 7'h01;
    end
  end

  // second function select pin, three stages, change on agreement
  logic [2:0] rt_sync_reg;
  logic       rt_q;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rt_sync_reg <= 3'h0;
      rt_q        <= 1'b0;
    end else begin
      rt_sync_reg <= {rt_sync_reg[1:0], second_function_select_i};
      if (rt_sync_reg[1] == rt_sync_reg[2]) begin
        rt_q <= rt_sync_reg[1];
      end
    end
  end

  // slip estimate: slip x base frequency x load, in 0.01 Hz
  logic [47:0] slip_prod;
  logic [15:0] slip_tgt;
  logic        slip_on;
  logic        slip_step;
  logic [9:0]  tc_reg;
  logic [26:0] filt_reg; // 10 fraction bits
  assign slip_prod = 48'(slip) * 48'(fbase) * 48'(out_current_i);
  assign slip_tgt  = 16'(slip_prod / `SC_SLIP_DIV);
  // 9999 on the range select keeps compensation at any speed
  assign slip_on = slip != 16'h0000 && slip != `SC_NONE &&
                   !(cpsel == 16'h0000 &&
                     out_freq_i > fbase);
  assign slip_step = tick_10us && tc_reg >= 10'(tcon - 16'h0001);

  // step spacing is the time constant times 10 us
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tc_reg <= 10'h000;
    end else if (tick_10us) begin
      tc_reg <= slip_step ? 10'h000 : tc_reg + 10'h001;
    end
  end

  // first-order lag, 1/1024 per step; tau approx setting x 10.24 ms
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      filt_reg <= 27'h000_0000;
    end else if (slip_step) begin
      filt_reg <= filt_reg + 27'(slip_tgt) - (filt_reg >> 10);
    end
  end

  // gating is immediate, the filter keeps running underneath
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      slip_comp_freq_o <= 16'h0000;
    end else begin
      slip_comp_freq_o <= slip_on ? filt_reg[25:10] : 16'h0000;
    end
  end

  a_slip_off: assert property (
    slip == 16'h0000 || slip == `SC_NONE
    |=> slip_comp_freq_o == 16'h0000)
    else $error("slip compensation while disabled");
  a_cp_cut: assert property (
    cpsel == 16'h0000 && out_freq_i > fbase
    |=> slip_comp_freq_o == 16'h0000)
    else $error("slip compensation above base frequency");
  a_slip_step: assert property (
    !slip_step |=> $stable(filt_reg))
    else $error("slip filter moved between steps");

  // active stall level in 0.1 percent of rated current
  int          d_ana;
  int          a_hf;
  int          l_hf;
  logic [15:0] lvl_main;
  logic [15:0] lvl_act;
  logic        use2;
  logic        over;
  logic        act;
  logic        fast;

  // second level: not during acceleration
  assign use2 = lvl2 != 16'h0000 && frq2 != 16'h0000 &&
                !accel_i &&
                ((frq2 == `SC_NONE) ? rt_q :
                 out_freq_i <= frq2);

  always_comb begin
    d_ana = (int'(ana10) - int'(ana0)) * int'(analog_level_i);
    lvl_main = lvl1;
    if (lvl1 == `SC_NONE) begin
      lvl_main = 16'(int'(ana0) + (d_ana >>> 12));
    end
    a_hf = 0;
    l_hf = int'(lvl_main);
    // reduction above the start frequency; 9999 keeps it flat
    if (fac != `SC_NONE && out_freq_i > fred) begin
      a_hf = int'(lvl_main) * int'(fred) / int'(out_freq_i);
      l_hf = a_hf + (int'(lvl_main) - a_hf) *
             (int'(fac) - int'(`SC_PCT100)) / int'(`SC_PCT100);
      if (l_hf < 0) begin
        l_hf = 0;
      end
    end
    lvl_act = use2 ? lvl2 : 16'(l_hf);
  end

  assign over = lvl1 != 16'h0000 &&
                out_current_i > lvl_act;
  // phase decides which action the operation select allows
  assign act  = over &&
                (accel_i ? !sc_op_off(opsel, 1) :
                 decel_i ? !sc_op_off(opsel, 3) :
                           !sc_op_off(opsel, 2));
  assign fast = !sc_op_off(opsel, 0) &&
                out_current_i > FAST_LVL;

  // stall actions, voltage reduction and output shutoff
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      stall_hold_accel_o <= 1'b0;
      stall_decel_o      <= 1'b0;
      stall_hold_decel_o <= 1'b0;
      voltage_reduce_o   <= 1'b0;
      output_shutoff_o   <= 1'b0;
    end else begin
      stall_hold_accel_o <= act && accel_i;
      stall_decel_o      <= act && !accel_i && !decel_i;
      stall_hold_decel_o <= act && !accel_i && decel_i;
      voltage_reduce_o   <= act && vred == 16'h0000;
      // a flagged overload stops the output when bit 4 asks so
      output_shutoff_o   <= fast || (overload_stall_flag_o &&
                            sc_op_off(opsel, 4));
    end
  end

  a_stall_off: assert property (
    lvl1 == 16'h0000 |=> !stall_hold_accel_o && !stall_decel_o &&
    !stall_hold_decel_o)
    else $error("stall action with level zero");
  a_accel_hold: assert property (
    over && accel_i && !sc_op_off(opsel, 1)
    |=> stall_hold_accel_o)
    else $error("acceleration not held on stall");
  a_volt_red: assert property (
    act && vred == 16'h0000 |=> voltage_reduce_o)
    else $error("voltage not reduced in stall");
  a_fast_cut: assert property (
    !sc_op_off(opsel, 0) && out_current_i > FAST_LVL
    |=> output_shutoff_o)
    else $error("fast limit did not shut off");

  // overload flag: delay, then a minimum on time
  sc_flag_state_type fst_reg;
  logic [14:0] dcnt_reg; // elapsed delay, ms
  logic [14:0] dly_ms;   // delay setting in ms
  logic [6:0]  hold_reg; // on time, ms
  assign dly_ms = 15'(int'(dly) * `SC_OL_UNIT_MS);
  assign overload_stall_flag_o = fst_reg == SC_FLAG_ON;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      fst_reg  <= SC_FLAG_IDLE;
      dcnt_reg <= 15'h0000;
    end else begin
      case (fst_reg)
        SC_FLAG_IDLE: begin
          dcnt_reg <= 15'h0000;
          if (act && dly != `SC_NONE) begin
            fst_reg <= (dly == 16'h0000) ? SC_FLAG_ON : SC_FLAG_WAIT;
          end
        end
        SC_FLAG_WAIT: begin
          // a stall shorter than the delay never shows
          if (!act || dly == `SC_NONE) begin
            fst_reg <= SC_FLAG_IDLE;
          end else if (dcnt_reg >= dly_ms) begin
            fst_reg <= SC_FLAG_ON;
          end else if (tick_ms) begin
            dcnt_reg <= dcnt_reg + 15'h0001;
          end
        end
        SC_FLAG_ON: begin
          if (dly == `SC_NONE || (hold_reg > 7'(`SC_OL_HOLD_MS) &&
              !over)) begin
            fst_reg <= SC_FLAG_IDLE;
          end
        end
        default: fst_reg <= SC_FLAG_IDLE;
      endcase
    end
  end

  // whole ms ticks beyond 100 guarantee more than 100 ms
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || fst_reg != SC_FLAG_ON) begin
      hold_reg <= 7'h00;
    end else if (tick_ms && hold_reg <= 7'(`SC_OL_HOLD_MS)) begin
      hold_reg <= hold_reg + 7'h01;
    end
  end

  a_flag_none: assert property (
    dly == `SC_NONE |=> !overload_stall_flag_o)
    else $error("flag shown while suppressed");
  a_flag_now: assert property (
    fst_reg == SC_FLAG_IDLE && act && dly == 16'h0000
    |=> overload_stall_flag_o)
    else $error("flag not immediate with zero delay");
  a_flag_hold: assert property (
    $fell(overload_stall_flag_o) |-> $past(dly) == `SC_NONE ||
    $past(hold_reg) > 7'(`SC_OL_HOLD_MS))
    else $error("flag dropped before its minimum time");

  // read mux: control, settings in pairs, status
  always_comb begin
    rd_word = 32'h0000_0000;
    // unmapped words alias control, setting or status words in widx, so test them first
    if (unmapped) begin
      rd_word = 32'h0000_0000;
    end else if (widx == `SC_W_CTRL) begin
      rd_word = {15'h0000, rate_reg, ugrs_reg};
    end else if (widx == `SC_W_STAT) begin
      rd_word = {slip_comp_freq_o, 10'h000, use2, rt_q,
                 voltage_reduce_o, output_shutoff_o,
                 overload_stall_flag_o, act};
    end else begin
      rd_word = {prm_reg[{widx[2:0], 1'b1}],
                 prm_reg[{widx[2:0], 1'b0}]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      rdata_reg <= rd_word;
    end
  end

endmodule

// ==== tb/sc_motor_model.sv ====
// behavioural power stage: current, speed, phase and analog level
// assumes bench commands on clk_i; follows them one edge later
`timescale 1ns/1ns
module sc_motor_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] cur_cmd_i,
  input  wire logic [15:0] freq_cmd_i,
  input  wire logic [1:0]  phase_cmd_i,
  input  wire logic [11:0] ana_cmd_i,
  input  wire logic        sel_cmd_i,
  output logic      [15:0] out_current_o,
  output logic      [15:0] out_freq_o,
  output logic      [11:0] analog_level_o,
  output logic             accel_o,
  output logic             decel_o,
  output logic             second_function_select_o
);
  // sensors settle one edge late, like a sampled converter would
  always @(posedge clk_i) begin
    out_current_o            <= cur_cmd_i;
    out_freq_o               <= freq_cmd_i;
    analog_level_o           <= ana_cmd_i;
    // phase code 1 accelerates, 2 decelerates, else steady speed
    accel_o                  <= (phase_cmd_i == 2'd1);
    decel_o                  <= (phase_cmd_i == 2'd2);
    second_function_select_o <= sel_cmd_i;
  end
endmodule

// ==== tb/sc_slip_stall_bench.sv ====
// bench for the slip and stall core: apb settings, motor stimulus
// assumes apb answers whenever pready is high, and a 125 MHz clock
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  num_errors++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module sc_slip_stall_bench;
  typedef struct {logic rd; logic [31:0] d; logic er;} sc_exp_type;
  logic        clk_i, reset_n_i, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] cur_cmd, freq_cmd, cur, frq, slip;
  logic [11:0] ana_cmd, ana;
  logic [1:0]  phase_cmd;
  logic        sel_cmd, sel, acc, dec;
  logic        h_acc, s_dec, h_dec, vred, shut, flag;
  sc_exp_type  exp_q[$];          // notes of expected apb answers
  sc_exp_type  mon_e;
  int          num_errors, cmp_count, i;
  int          seed = 32'h07c4225e;
  logic [5:0]  op_exp[4] = '{6'b010101, 6'b000001, 6'b010111,
                             6'b010111};
  logic [15:0] op_cur[4] = '{16'h076c, 16'h04b0, 16'h04b0, 16'h076c};
  logic [15:0] op_val[4] = '{16'h0001, 16'h0004, 16'h0010, 16'h0064};

  sc_slip_stall i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .out_current_i(cur),
    .out_freq_i(frq), .analog_level_i(ana), .accel_i(acc),
    .decel_i(dec), .second_function_select_i(sel),
    .slip_comp_freq_o(slip), .stall_hold_accel_o(h_acc),
    .stall_decel_o(s_dec), .stall_hold_decel_o(h_dec),
    .voltage_reduce_o(vred), .output_shutoff_o(shut),
    .overload_stall_flag_o(flag));
  sc_motor_model i_motor (.clk_i(clk_i), .cur_cmd_i(cur_cmd),
    .freq_cmd_i(freq_cmd), .phase_cmd_i(phase_cmd), .ana_cmd_i(ana_cmd),
    .sel_cmd_i(sel_cmd), .out_current_o(cur), .out_freq_o(frq),
    .analog_level_o(ana), .accel_o(acc), .decel_o(dec),
    .second_function_select_o(sel));

  // free-running 8 ns clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // one apb transfer; the answer is noted before it can appear
  // waits for pready however long it takes; only the watchdog ends a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [31:0] ex, input logic er);
    @(posedge clk_i);
    exp_q.push_back('{!w, ex, er});
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin @(posedge clk_i); end while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // set a load point, let model and core settle (levels, not pulses)
  task motor(input logic [15:0] c, input logic [1:0] ph,
             input logic [15:0] f);
    @(posedge clk_i);
    cur_cmd <= c; phase_cmd <= ph; freq_cmd <= f;
    ana_cmd <= 12'($random(seed)); sel_cmd <= 1'($random(seed));
    repeat (5) @(posedge clk_i);
    #1;
  endtask

  task stall_is(input logic [5:0] ex);
    `CHK("stall", ex, {h_acc, s_dec, h_dec, vred, shut, flag})
  endtask

  task print_verdict;
    $display("errors %0d checks %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // scoreboard: every completed access takes the oldest note
  always @(posedge clk_i) begin
    if (psel && penable && pready === 1'b1) begin
      mon_e = exp_q.pop_front();
      if (mon_e.rd) `CHK("prdata", mon_e.d, prdata)
      `CHK("pslverr", mon_e.er, pslverr)
    end
  end

  // hang guard, well past the few thousand cycles the tests need
  initial begin
    #(8 * 60000);
    num_errors++;
    print_verdict;
  end

  initial begin
    reset_n_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; cur_cmd = 16'h0000;
    freq_cmd = 16'h0000; phase_cmd = 2'd0; ana_cmd = 12'h000;
    sel_cmd = 1'b0;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    apb(0, 8'h0C, 0, 32'hFFFF_044C, 0);
    apb(0, 8'h1C, 0, 32'h0001_0000, 0);
    apb(0, 8'h04, 0, 32'h0032_FFFF, 0);
    apb(0, 8'h10, 0, 32'h0000_044C, 0);
    apb(0, 8'h40, 0, 32'h0000_0000, 1);
    apb(1, 8'h20, 32'hFFFF_FFFF, 0, 0);
    // just above the level, accelerating then twice at steady speed, random low speed
    for (i = 0; i < 3; i++) begin
      motor(16'h044D, 2'(i + 1) % 3 == 0 ? 2'd0 : 2'(i == 0 ? 1 : 0),
            16'(($random(seed) & 32'h0fff)));
      stall_is(i == 0 ? 6'b100001 : 6'b010001);
    end
    motor(16'h044D, 2'd2, 16'h03e8);
    stall_is(6'b001001);
    `CHK("slip", 16'h0000, slip)
    motor(16'h044B, 2'd0, 16'h03e8);
    stall_is(6'b000001);
    apb(1, 8'h1C, 32'h0000_0000, 0, 0);
    motor(16'h04b0, 2'd0, 16'h03e8);
    stall_is(6'b010101);
    motor(16'h076c, 2'd0, 16'h03e8);
    stall_is(6'b010111);
    // bit 4 (output stops while flagged) is exercised by the third entry
    for (i = 0; i < 4; i++) begin
      apb(1, 8'h18, {op_val[i], 16'h1388}, 0, 0);
      motor(op_cur[i], 2'd0, 16'h03e8);
      stall_is(op_exp[i]);
    end
    apb(1, 8'h0C, 32'hFFFF_0000, 0, 0);
    motor(16'h05dc, 2'd1, 16'h03e8);
    stall_is(6'b000001);
    apb(1, 8'h00, 32'h0000_0001, 0, 0);
    apb(1, 8'h0C, 32'hFFFF_044C, 0, 1);
    apb(0, 8'h0C, 0, 32'hFFFF_0000, 0);
    apb(1, 8'h00, 32'h0000_0000, 0, 0);
    apb(1, 8'h04, 32'h0001_1388, 0, 0);
    apb(1, 8'h08, 32'h1388_0000, 0, 0);
    motor(16'h0320, 2'd0, 16'h1770);
    `CHK("slip", 16'h0000, slip)
    // range select 9999: target 5000*5000*4000/1e7 = 10000, filter rising
    apb(1, 8'h08, 32'h1388_FFFF, 0, 0);
    motor(16'h0fa0, 2'd0, 16'h1770);
    repeat (3750) @(posedge clk_i);
    #1;
    `CHK("slip_on", 1'b1, slip > 16'h0000 && slip <= 16'h2710)
    // delay 9999 drops a standing flag; level is 0 here, so the load point after it is no stall
    apb(1, 8'h1C, 32'h0000_FFFF, 0, 0);
    motor(16'h04b0, 2'd0, 16'h03e8);
    `CHK("flag", 1'b0, flag)
    print_verdict;
  end
endmodule
